/* include/fso_status_map.svh */
// Constants for the live status-one register bank: opcodes, bit positions,
// reset values and the register-read addresses.
// Assumes an SPI front end that decodes whole commands before handing them on.
`ifndef FSO_STATUS_MAP_SVH
`define FSO_STATUS_MAP_SVH

`define FSO_BIT_LOCK        7
`define FSO_BIT_GRANULE     6
`define FSO_BIT_REFERENCE   5
`define FSO_BIT_RANGE_MSB   4
`define FSO_BIT_RANGE_LSB   2
`define FSO_BIT_WEL         1
`define FSO_BIT_BUSY        0

`define FSO_IMAGE_RESET     8'h00
`define FSO_ARRAY_BYTES     24'h800000
`define FSO_SECTOR_BYTES    24'h001000

`define FSO_CMD_WRITE_ENABLE_COMMAND        8'h06
`define FSO_CMD_VOLATILE_WRITE_ENABLE_COMMAND       8'h50
`define FSO_CMD_WRITE_DISABLE_COMMAND        8'h04
`define FSO_CMD_WRR         8'h01
`define FSO_CMD_ANY_REGISTER_WRITE_COMMAND        8'h71
`define FSO_CMD_CLEAR_STATUS_COMMAND        8'h30
`define FSO_CMD_STATUS_ONE_READ_COMMAND       8'h05
`define FSO_CMD_STATUS_TWO_READ_COMMAND       8'h07
`define FSO_CMD_ANY_REGISTER_READ_COMMAND        8'h65
`define FSO_CMD_SUSPEND     8'h75
`define FSO_CMD_RST_EN      8'h66
`define FSO_CMD_RST         8'h99
`define FSO_CMD_PROGRAM     8'h02
`define FSO_CMD_ERASE_4K    8'h20
`define FSO_CMD_ERASE_32K   8'h52
`define FSO_CMD_ERASE_64K   8'hD8
`define FSO_CMD_ERASE_CHIP  8'h60
`define FSO_CMD_ERASE_CHIP2 8'hC7

`define FSO_ADDR_IMAGE      8'h00
`define FSO_ADDR_LIVE       8'h80
`define FSO_ADDR_STATUS_TWO 8'h81

`endif

/* include/fso_pkg.sv */
// Types shared by the status-one register bank modules.
// Assumes nothing beyond the constants header.
package fso_pkg;

  typedef logic [7:0] fso_byte_t;

  typedef enum logic [1:0] {
    fso_op_none     = 2'b00,
    fso_op_program  = 2'b01,
    fso_op_erase    = 2'b10,
    fso_op_register = 2'b11
  } fso_op_e;

endpackage

/* rtl/fso_range_check.sv */
// Legacy range protection decode: tells whether an array address is covered.
// Assumes an 8 MB array addressed by 23 byte-address bits.
`timescale 1ns/1ps
`include "fso_status_map.svh"

module fso_range_check (
  // Protection fields
  input  wire logic [2:0]  range_bits,
  input  wire logic        granule_size_select,
  input  wire logic        range_reference_select,
  // Target
  input  wire logic [22:0] target_addr,
  input  wire logic        whole_array,
  // Result
  output logic             hit
);
  import fso_pkg::*;

  logic [23:0] span;
  logic [23:0] addr_ext;

  always_comb begin
    span = 24'h000000;
    if (range_bits == 3'h7) begin
      span = `FSO_ARRAY_BYTES;
    end else if (range_bits != 3'h0) begin
      if (granule_size_select) begin
        span = `FSO_SECTOR_BYTES << (range_bits - 3'h1);
      end else begin
        span = `FSO_ARRAY_BYTES >> (3'h7 - range_bits);
      end
    end
  end

  assign addr_ext = {1'b0, target_addr};

  always_comb begin
    if (whole_array) begin
      hit = (range_bits != 3'h0);
    end else if (range_reference_select) begin
      hit = (addr_ext < span);
    end else begin
      hit = (span != 24'h000000) && (addr_ext >= (`FSO_ARRAY_BYTES - span));
    end
  end

endmodule // fso_range_check

/* rtl/fso_cmd_gate.sv */
// Command admission: decides whether a decoded command may act at all.
// Assumes one command offered per cycle by the SPI front end.
`timescale 1ns/1ps
`include "fso_status_map.svh"

module fso_cmd_gate (
  // Command
  input  wire logic [7:0] cmd_code,
  // Device state
  input  wire logic       busy,
  input  wire logic       array_op_running,
  input  wire logic       registers_locked,
  // Verdict
  output logic            accept
);
  import fso_pkg::*;

  logic busy_ok;
  logic is_reg_write;

  always_comb begin
    unique case (cmd_code)
      `FSO_CMD_STATUS_ONE_READ_COMMAND, `FSO_CMD_STATUS_TWO_READ_COMMAND, `FSO_CMD_ANY_REGISTER_READ_COMMAND, `FSO_CMD_CLEAR_STATUS_COMMAND,
      `FSO_CMD_RST_EN, `FSO_CMD_RST: busy_ok = 1'b1;
      default:                      busy_ok = 1'b0;
    endcase
  end

  assign is_reg_write = (cmd_code == `FSO_CMD_WRR) || (cmd_code == `FSO_CMD_ANY_REGISTER_WRITE_COMMAND);

  always_comb begin
    if (cmd_code == `FSO_CMD_SUSPEND) begin
      accept = array_op_running;
    end else if (busy) begin
      accept = busy_ok;
    end else begin
      accept = !(is_reg_write && registers_locked);
    end
  end

endmodule // fso_cmd_gate

/* rtl/fso_status_one.sv */
// Status register one of a serial NOR flash: live copy, its default image,
// write enable latch, busy flag and the command admission around them.
// Assumes a front end that delivers whole decoded commands as one-cycle
// strobes and an array engine that reports completion of each operation.
`timescale 1ns/1ps
`include "fso_status_map.svh"

module fso_status_one (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                reset_n,
  // Other reset sources
  input  wire logic                hard_reset,
  // Decoded command
  input  wire logic                cmd_valid,
  input  wire logic [7:0]          cmd_code,
  input  wire logic [7:0]          cmd_addr_reg,
  input  wire logic [22:0]         cmd_addr_array,
  input  wire fso_pkg::fso_byte_t  cmd_data,
  // Pins and mode bits
  input  wire logic                write_protect_pin_n,
  input  wire logic                four_wire_command_mode,
  input  wire logic                four_wire_data_mode,
  // Array engine
  input  wire logic                op_done,
  input  wire logic                op_failed,
  output logic                     op_start,
  output fso_pkg::fso_op_e         op_kind,
  output logic [22:0]              op_addr,
  output logic                     op_whole_array,
  output logic                     suspend_req,
  // Register views
  output fso_pkg::fso_byte_t       status_one_live,
  output fso_pkg::fso_byte_t       status_one_default_image,
  output logic                     program_error,
  output logic                     erase_error,
  output logic                     registers_locked,
  // Read answer
  output logic                     read_valid,
  output fso_pkg::fso_byte_t       read_data
);
  import fso_pkg::*;

  // State
  logic [7:2]  cfg;
  logic [7:2]  image_cfg;
  logic        write_enable_latch;
  logic        busy;
  logic        nv_enable;
  logic        reset_armed;
  fso_op_e     running;
  logic        p_err;
  logic        e_err;

  // Next values
  logic [7:2]  next_cfg;
  logic [7:2]  next_image_cfg;
  logic        next_wel;
  logic        next_busy;
  logic        next_p_err;
  logic        next_e_err;

  // Decode
  logic        accept;
  logic        take;
  logic        internal_wp;
  logic        locked;
  logic        reload;
  logic        is_program;
  logic        is_erase;
  logic        is_chip;
  logic        is_array;
  logic        reg_write;
  logic        write_image;
  logic        write_live;
  logic        array_start;
  logic        range_hit;
  logic        array_running;
  logic        fail_now;
  logic        ok_now;
  fso_byte_t   status_two;

  assign internal_wp = write_protect_pin_n | four_wire_command_mode | four_wire_data_mode;

  assign locked = cfg[`FSO_BIT_LOCK] & ~internal_wp;

  assign array_running = busy && ((running == fso_op_program) || (running == fso_op_erase))
                         && !p_err && !e_err;

  fso_cmd_gate u_gate (
    .cmd_code         (cmd_code),
    .busy             (busy),
    .array_op_running (array_running),
    .registers_locked (locked),
    .accept           (accept)
  );

  assign take = cmd_valid & accept;

  assign is_program = (cmd_code == `FSO_CMD_PROGRAM);
  assign is_chip    = (cmd_code == `FSO_CMD_ERASE_CHIP) || (cmd_code == `FSO_CMD_ERASE_CHIP2);
  assign is_erase   = is_chip || (cmd_code == `FSO_CMD_ERASE_4K) ||
                      (cmd_code == `FSO_CMD_ERASE_32K) || (cmd_code == `FSO_CMD_ERASE_64K);
  assign is_array   = is_program | is_erase;

  fso_range_check u_range (
    .range_bits             (cfg[`FSO_BIT_RANGE_MSB:`FSO_BIT_RANGE_LSB]),
    .granule_size_select    (cfg[`FSO_BIT_GRANULE]),
    .range_reference_select (cfg[`FSO_BIT_REFERENCE]),
    .target_addr            (cmd_addr_array),
    .whole_array            (is_chip),
    .hit                    (range_hit)
  );

  // second half of the reset pair
  assign reload = hard_reset | (take && (cmd_code == `FSO_CMD_RST) && reset_armed);

  assign reg_write = take && write_enable_latch &&
                     ((cmd_code == `FSO_CMD_WRR) ||
                      ((cmd_code == `FSO_CMD_ANY_REGISTER_WRITE_COMMAND) &&
                       ((cmd_addr_reg == `FSO_ADDR_IMAGE) || (cmd_addr_reg == `FSO_ADDR_LIVE))));

  // Image is written by the non-volatile path only
  assign write_image = reg_write &&
                       (((cmd_code == `FSO_CMD_WRR) && nv_enable) ||
                        ((cmd_code == `FSO_CMD_ANY_REGISTER_WRITE_COMMAND) && (cmd_addr_reg == `FSO_ADDR_IMAGE)));
  assign write_live  = reg_write && !write_image;

  assign array_start = take && write_enable_latch && is_array;

  assign fail_now = busy && op_done && op_failed;
  assign ok_now   = busy && op_done && !op_failed;

  // Configuration fields and their default image
  always_comb begin
    next_image_cfg = image_cfg;
    next_cfg       = cfg;
    if (write_image) begin
      next_image_cfg = cmd_data[7:2];
      next_cfg = cmd_data[7:2];
    end else if (write_live) begin
      next_cfg = cmd_data[7:2];
    end
    if (reload) begin
      next_cfg = image_cfg;
    end
  end

  // Write enable latch
  always_comb begin
    next_wel = write_enable_latch;
    if (take && ((cmd_code == `FSO_CMD_WRITE_ENABLE_COMMAND) || (cmd_code == `FSO_CMD_VOLATILE_WRITE_ENABLE_COMMAND))) begin
      next_wel = 1'b1;
    end else if (take && ((cmd_code == `FSO_CMD_WRITE_DISABLE_COMMAND) || (cmd_code == `FSO_CMD_CLEAR_STATUS_COMMAND))) begin
      next_wel = 1'b0;
    end else if (reg_write) begin
      // cleared in the cycle the write is taken, not from data
      next_wel = 1'b0;
    end
    if (ok_now) begin
      next_wel = 1'b0;
    end
    if (reload) begin
      next_wel = 1'(`FSO_IMAGE_RESET >> `FSO_BIT_WEL);
    end
  end

  // Busy flag and error flags
  always_comb begin
    next_busy  = busy;
    next_p_err = p_err;
    next_e_err = e_err;
    if (take && (cmd_code == `FSO_CMD_CLEAR_STATUS_COMMAND)) begin
      next_p_err = 1'b0;
      next_e_err = 1'b0;
      if (p_err || e_err) begin
        next_busy = 1'b0;
      end
    end
    if (array_start) begin
      next_busy = 1'b1;
      if (range_hit) begin
        next_p_err = is_program;
        next_e_err = is_erase;
      end
    end
    // errors set while busy win over clear
    if (fail_now) begin
      next_p_err = next_p_err | (running == fso_op_program);
      next_e_err = next_e_err | (running == fso_op_erase);
    end else if (ok_now) begin
      next_busy = 1'b0;
    end
    if (reload) begin
      next_busy  = 1'(`FSO_IMAGE_RESET >> `FSO_BIT_BUSY);
      next_p_err = 1'b0;
      next_e_err = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      image_cfg <= 6'(`FSO_IMAGE_RESET >> `FSO_BIT_RANGE_LSB);
      cfg       <= 6'(`FSO_IMAGE_RESET >> `FSO_BIT_RANGE_LSB);
    end else begin
      image_cfg <= next_image_cfg;
      cfg       <= next_cfg;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      write_enable_latch   <= 1'(`FSO_IMAGE_RESET >> `FSO_BIT_WEL);
      busy  <= 1'(`FSO_IMAGE_RESET >> `FSO_BIT_BUSY);
      p_err <= 1'b0;
      e_err <= 1'b0;
    end else begin
      write_enable_latch   <= next_wel;
      busy  <= next_busy;
      p_err <= next_p_err;
      e_err <= next_e_err;
    end
  end

  // Remembers which enable command armed the latch
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      nv_enable <= 1'b0;
    end else if (reload) begin
      nv_enable <= 1'b0;
    end else if (take && (cmd_code == `FSO_CMD_WRITE_ENABLE_COMMAND)) begin
      nv_enable <= 1'b1;
    end else if (take && (cmd_code == `FSO_CMD_VOLATILE_WRITE_ENABLE_COMMAND)) begin
      nv_enable <= 1'b0;
    end
  end

  // first half arms, any other accepted command disarms
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reset_armed <= 1'b0;
    end else if (take) begin
      reset_armed <= (cmd_code == `FSO_CMD_RST_EN);
    end
  end

  // Operation in flight, kept until busy ends
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      running <= fso_op_none;
    end else if (reload || !next_busy) begin
      running <= fso_op_none;
    end else if (array_start) begin
      running <= is_program ? fso_op_program : fso_op_erase;
    end
  end

  // Start strobe toward the array engine; protected targets never start
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      op_start       <= 1'b0;
      op_kind        <= fso_op_none;
      op_addr        <= 23'h000000;
      op_whole_array <= 1'b0;
    end else begin
      op_start <= array_start && !range_hit && !reload;
      if (array_start) begin
        op_kind        <= is_program ? fso_op_program : fso_op_erase;
        op_addr        <= cmd_addr_array;
        op_whole_array <= is_chip;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      suspend_req <= 1'b0;
    end else begin
      suspend_req <= take && (cmd_code == `FSO_CMD_SUSPEND);
    end
  end

  // Published views, built from next values so they never lag state
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      status_one_live          <= `FSO_IMAGE_RESET;
      status_one_default_image <= `FSO_IMAGE_RESET;
      program_error            <= 1'b0;
      erase_error              <= 1'b0;
      registers_locked         <= 1'b0;
    end else begin
      status_one_live          <= {next_cfg, next_wel, next_busy};
      status_one_default_image <= {next_image_cfg, 2'b00};
      program_error            <= next_p_err;
      erase_error              <= next_e_err;
      registers_locked         <= next_cfg[`FSO_BIT_LOCK] & ~internal_wp;
    end
  end

  assign status_two = {1'b0, e_err, p_err, 5'b00000};

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      read_valid <= 1'b0;
      read_data  <= 8'h00;
    end else begin
      read_valid <= 1'b0;
      if (take && (cmd_code == `FSO_CMD_STATUS_ONE_READ_COMMAND)) begin
        read_valid <= 1'b1;
        read_data  <= {cfg, write_enable_latch, busy};
      end else if (take && (cmd_code == `FSO_CMD_STATUS_TWO_READ_COMMAND)) begin
        read_valid <= 1'b1;
        read_data  <= status_two;
      end else if (take && (cmd_code == `FSO_CMD_ANY_REGISTER_READ_COMMAND)) begin
        read_valid <= 1'b1;
        unique case (cmd_addr_reg)
          `FSO_ADDR_IMAGE:      read_data <= {image_cfg, 2'b00};
          `FSO_ADDR_LIVE:       read_data <= {cfg, write_enable_latch, busy};
          `FSO_ADDR_STATUS_TWO: read_data <= status_two;
          default:              read_data <= 8'h00;
        endcase
      end
    end
  end

endmodule // fso_status_one

/* test/fso_engine_model.sv */
// Array engine stand-in: answers each started operation after a set latency.
// Assumes op_start is a one-cycle pulse and only one operation is outstanding.
`timescale 1ns/1ps

module fso_engine_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // Control from the bench
  input  wire logic [3:0] latency,
  input  wire logic       fail_next,
  // Engine handshake
  input  wire logic       op_start,
  output logic            op_done,
  output logic            op_failed
);
  logic [3:0] count;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count     <= 4'h0;
      op_done   <= 1'b0;
      op_failed <= 1'b1;
    end else begin
      op_done <= (count == 4'h1);
      // Outside the done cycle the flag toggles, so nothing may rely on it
      op_failed <= (count == 4'h1) ? fail_next : ~op_failed;
      if (op_start) begin
        count <= latency;
      end else if (count != 4'h0) begin
        count <= count - 4'h1;
      end
    end
  end
endmodule // fso_engine_model

/* test/fso_status_one_props.sv */
// Checker for the status-one bank, watching only the top module's ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps

module fso_status_one_props (
  input wire logic               clock,
  input wire logic               reset_n,
  input wire logic               hard_reset,
  input wire logic               cmd_valid,
  input wire logic [7:0]         cmd_code,
  input wire logic               write_protect_pin_n,
  input wire logic               four_wire_command_mode,
  input wire logic               four_wire_data_mode,
  input wire logic               op_done,
  input wire logic               op_failed,
  input wire logic               op_start,
  input wire logic               suspend_req,
  input wire fso_pkg::fso_byte_t status_one_live,
  input wire fso_pkg::fso_byte_t status_one_default_image,
  input wire logic               program_error,
  input wire logic               erase_error,
  input wire logic               read_valid,
  input wire fso_pkg::fso_byte_t read_data
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic busy;
  logic go;
  assign busy = status_one_live[0];
  assign go = cmd_valid && !hard_reset;

  AST_WRITE_ENABLE_COMMAND_SETS: assert property (go && cmd_code == 8'h06 && !busy |=> status_one_live[1])
    else $error("write enable did not set latch");
  AST_WRITE_DISABLE_COMMAND_CLEARS: assert property (go && cmd_code == 8'h04 && !busy |=> !status_one_live[1])
    else $error("write disable did not clear latch");
  AST_READ_LIVE: assert property (go && cmd_code == 8'h05 && !op_done
    |=> read_valid && read_data == $past(status_one_live))
    else $error("status read wrong");
  AST_START_NEEDS_WEL: assert property (op_start |-> busy && $past(status_one_live[1]))
    else $error("operation started without latch");
  AST_ERROR_KEEPS_BUSY: assert property (program_error || erase_error |-> busy)
    else $error("error without busy");
  AST_DONE_IDLES: assert property (busy && op_done && !op_failed && !program_error && !erase_error
    && !hard_reset |=> status_one_live[1:0] == 2'b00)
    else $error("success did not clear busy and latch");
  AST_REGWRITE_NO_BUSY: assert property (go && cmd_code inside {8'h01, 8'h71} && !busy |=> !busy)
    else $error("register write set busy");
  AST_LOCK_FREEZES: assert property (go && cmd_code inside {8'h01, 8'h71} && status_one_live[7]
    && !write_protect_pin_n && !four_wire_command_mode && !four_wire_data_mode
    |=> $stable(status_one_live) && $stable(status_one_default_image))
    else $error("locked register changed");
  AST_SUSPEND_IDLE: assert property (go && cmd_code == 8'h75 && !busy |=> !suspend_req)
    else $error("suspend accepted while idle");
  AST_CLEAR_STATUS: assert property (go && cmd_code == 8'h30 && !op_done && (program_error || erase_error || !busy)
    |=> !program_error && !erase_error && !busy)
    else $error("clear status left busy or error");
  AST_HARD_RELOAD: assert property (hard_reset && !cmd_valid
    |=> status_one_live == {$past(status_one_default_image[7:2]), 2'b00})
    else $error("hard reset did not reload");
endmodule // fso_status_one_props

bind fso_status_one fso_status_one_props i_fso_status_one_props (.clock, .reset_n, .hard_reset, .cmd_valid,
  .cmd_code, .write_protect_pin_n, .four_wire_command_mode, .four_wire_data_mode, .op_done, .op_failed,
  .op_start, .suspend_req, .status_one_live, .status_one_default_image, .program_error, .erase_error,
  .read_valid, .read_data);

/* test/testbench.sv */
// Self-checking bench for the status-one bank with an array engine model.
// Assumes the decoded-command strobe contract; inputs change at falling edges.
`timescale 1ns/1ps

module testbench;
  import fso_pkg::*;
  typedef struct {logic [7:0] code; logic [7:0] data; logic [7:0] reg_addr; logic [7:0] live;} fso_row_s;
  logic        clock = 1'b0, reset_n = 1'b0, hard_reset = 1'b0, cmd_valid = 1'b0, fail_next = 1'b0;
  logic [7:0]  cmd_code = 8'h00, cmd_addr_reg = 8'h00;
  logic [22:0] cmd_addr_array = 23'h000100, op_addr;
  logic        write_protect_pin_n = 1'b1, four_wire_command_mode = 1'b0, four_wire_data_mode = 1'b0;
  logic        op_done, op_failed, op_start, op_whole_array, suspend_req, program_error, erase_error;
  logic        registers_locked, read_valid;
  fso_op_e     op_kind;
  fso_byte_t   cmd_data = 8'h00, status_one_live, status_one_default_image, read_data;
  int          failures = 0, samples_checked = 0, cycles = 0;
  fso_row_s rows [12] = '{'{8'h06, 8'h00, 8'h00, 8'h02}, '{8'h01, 8'hA8, 8'h00, 8'hA8},
    '{8'h01, 8'hFC, 8'h00, 8'hA8}, '{8'h50, 8'h00, 8'h00, 8'hAA}, '{8'h01, 8'h04, 8'h00, 8'h04},
    '{8'h06, 8'h00, 8'h00, 8'h06}, '{8'h04, 8'h00, 8'h00, 8'h04}, '{8'h06, 8'h00, 8'h00, 8'h06},
    '{8'h71, 8'h9C, 8'h80, 8'h9C}, '{8'h06, 8'h00, 8'h00, 8'h9E}, '{8'h71, 8'h00, 8'h81, 8'h9E},
    '{8'h04, 8'h00, 8'h00, 8'h9C}};

  always #2.5 clock = ~clock;

  fso_status_one i_fso_status_one (.clock, .reset_n, .hard_reset, .cmd_valid, .cmd_code, .cmd_addr_reg,
    .cmd_addr_array, .cmd_data, .write_protect_pin_n, .four_wire_command_mode, .four_wire_data_mode,
    .op_done, .op_failed, .op_start, .op_kind, .op_addr, .op_whole_array, .suspend_req, .status_one_live,
    .status_one_default_image, .program_error, .erase_error, .registers_locked, .read_valid, .read_data);
  fso_engine_model i_fso_engine_model (.clock, .reset_n, .latency(4'h4), .fail_next, .op_start, .op_done,
    .op_failed);

  task automatic finish_test();
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One strobe; effects are settled at the falling edge it returns on
  task automatic cmd(input logic [7:0] c, input logic [7:0] d, input logic [7:0] r = 8'h00);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = d;
    cmd_addr_reg = r;
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask

  // Bounded wait for the error flags to rise
  task automatic wait_error();
    for (int i = 0; i < 20 && !(program_error === 1'b1 || erase_error === 1'b1); i++) @(negedge clock);
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles > 2000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    reset_n = 1'b1;
    check("reset live", status_one_live, 8'h00);
    foreach (rows[i]) begin
      cmd(rows[i].code, rows[i].data, rows[i].reg_addr);
      check("row live", status_one_live, rows[i].live);
    end
    check("image", status_one_default_image, 8'hA8);
    cmd(8'h05, 8'h00);
    check("read status", {read_valid, read_data}, 9'h19C);
    cmd(8'h65, 8'h00, 8'h00);
    check("read image", read_data, 8'hA8);
    @(negedge clock) hard_reset = 1'b1;
    @(negedge clock) hard_reset = 1'b0;
    check("hard reload", status_one_live, 8'hA8);
    write_protect_pin_n = 1'b0;
    cmd(8'h06, 8'h00);
    cmd(8'h01, 8'h00);
    check("locked", {registers_locked, status_one_live}, 9'h1AA);
    // Both quad modes must lift the lock, so write keeps bit 7 on the first pass
    for (int m = 0; m < 2; m++) begin
      {four_wire_command_mode, four_wire_data_mode} = m ? 2'b01 : 2'b10;
      cmd(8'h06, 8'h00);
      cmd(8'h01, m ? 8'h20 : 8'hA0);
      check("quad unlock", status_one_live, m ? 8'h20 : 8'hA0);
    end
    {four_wire_command_mode, four_wire_data_mode, write_protect_pin_n} = 3'b001;
    cmd(8'h06, 8'h00);
    cmd(8'h02, 8'h00);
    check("start", {op_start, status_one_live}, 9'h123);
    check("op addr", op_addr, 23'h000100);
    check("op kind", {op_whole_array, op_kind}, 3'b001);
    cmd(8'h04, 8'h00);
    check("busy refuse", status_one_live, 8'h23);
    cmd(8'h75, 8'h00);
    check("suspend busy", suspend_req, 1'b1);
    repeat (4) @(negedge clock);
    check("done", status_one_live, 8'h20);
    fail_next = 1'b1;
    cmd(8'h06, 8'h00);
    cmd(8'hD8, 8'h00);
    wait_error();
    check("erase fail", {erase_error, status_one_live[0]}, 2'b11);
    cmd(8'h07, 8'h00);
    check("read status two", {read_valid, read_data}, 9'h140);
    cmd(8'h65, 8'h00, 8'h80);
    check("read live busy", {read_valid, read_data}, 9'h123);
    cmd(8'h30, 8'h00);
    check("clear", {erase_error, status_one_live}, 9'h020);
    fail_next = 1'b0;
    cmd(8'h06, 8'h00);
    cmd(8'h01, 8'h3C);
    cmd(8'h06, 8'h00);
    cmd(8'h02, 8'h00);
    check("protected", {op_start, program_error, status_one_live[0]}, 3'b011);
    cmd(8'h30, 8'h00);
    cmd(8'h50, 8'h00);
    cmd(8'h01, 8'h00);
    cmd(8'h75, 8'h00);
    check("suspend idle", {suspend_req, status_one_live}, 9'h000);
    cmd(8'h66, 8'h00);
    cmd(8'h99, 8'h00);
    check("soft reset", status_one_live, 8'h3C);
    // Power-on reset in mid-run brings image and live copy back to defaults
    @(negedge clock) reset_n = 1'b0;
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    check("power on", {status_one_default_image, status_one_live}, 16'h0000);
    finish_test();
  end
endmodule // testbench
